/* File: design/mip_pkg.sv */
package mip_pkg;
    localparam logic [3:0] ADDR_FIXED = 4'h5;
    localparam logic [7:0] REG_OT_HIGH = 8'h3a;
    localparam logic [7:0] REG_OT_HYST = 8'h3b;
    localparam logic [7:0] REG_FAN1_LIM = 8'h3c;
    localparam logic [7:0] REG_FAN2_LIM = 8'h3d;
    localparam logic [7:0] REG_MAKER_ID = 8'h3e;
    localparam logic [7:0] RST_OT_HIGH = 8'h55;
    localparam logic [7:0] RST_OT_HYST = 8'h4b;
    localparam logic [7:0] RST_FAN_LIM = 8'hff;
    // Arbitrary neutral identification value
    localparam logic [7:0] MAKER_ID_VALUE = 8'h5c;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // Host side: bus clock rate and its register map
    localparam int CLK_HZ = 100000000;
    localparam int SCL_HZ = 100000;
    localparam int QUARTER_CYC = CLK_HZ / (SCL_HZ * 4);
    localparam logic [9:0] QUARTER_CNT = 10'(QUARTER_CYC - 1);
    localparam logic [1:0] HREG_CTRL = 2'h0;
    localparam logic [1:0] HREG_STATUS = 2'h1;
    localparam logic [1:0] HREG_DATA = 2'h2;
    localparam logic [1:0] HREG_REGIDX = 2'h3;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    typedef enum logic [1:0] {MIP_OP_PTR, MIP_OP_WRITE, MIP_OP_READ} mip_op_type;
endpackage

/* File: design/mip_i2c_if.sv */
`timescale 1ns/1ns
interface mip_i2c_if;
    logic scl_dev_o;
    logic scl_dev_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    // Open-drain wired level, pulled high when nobody drives low
    logic scl;
    logic sda;
    assign scl = !((scl_dev_oe && !scl_dev_o) || (scl_host_oe && !scl_host_o));
    assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
    modport device (
        input scl,
        input sda,
        output scl_dev_o,
        output scl_dev_oe,
        output sda_dev_o,
        output sda_dev_oe
    );
    modport host (
        input scl,
        input sda,
        output scl_host_o,
        output scl_host_oe,
        output sda_host_o,
        output sda_host_oe
    );
endinterface

/* File: design/mip_sync3.sv */
`timescale 1ns/1ns
module mip_sync3 (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic async_i,
    output logic level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // Change accepted only once two later stages agree
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            level_o <= 1'b1;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end
endmodule

/* File: design/mip_device.sv */
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module mip_device (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic addr_select_bit2_i,
    input wire logic addr_select_bit1_i,
    input wire logic addr_select_bit0_i,
    output logic [7:0] overtemp_high_limit_o,
    output logic [7:0] overtemp_hysteresis_limit_o,
    output logic [7:0] fan1_count_limit_o,
    output logic [7:0] fan2_count_limit_o,
    output logic [7:0] addr_pointer_o,
    mip_i2c_if.device bus
);
    typedef enum logic [2:0] {
        MIP_IDLE, MIP_ADDR, MIP_ACK, MIP_RX, MIP_TX, MIP_TX_ACK
    } mip_dev_state_type;

    mip_dev_state_type state_q;
    logic scl_s;
    logic sda_s;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [2:0] sel_s;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic read_q;
    logic [1:0] byte_cnt_q;
    logic sda_low_q;
    logic [7:0] rd_data;

    mip_sync3 u_scl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(bus.scl), .level_o(scl_s));
    mip_sync3 u_sda (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(bus.sda), .level_o(sda_s));
    // Select pins compared live at each address byte, so a change takes effect at the next address
    mip_sync3 u_a2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(addr_select_bit2_i),
        .level_o(sel_s[2]));
    mip_sync3 u_a1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(addr_select_bit1_i),
        .level_o(sel_s[1]));
    mip_sync3 u_a0 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(addr_select_bit0_i),
        .level_o(sel_s[0]));

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_match;
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign addr_match = (shift_q[7:1] == {mip_pkg::ADDR_FIXED, sel_s});

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (addr_pointer_o)
            mip_pkg::REG_OT_HIGH: rd_data = overtemp_high_limit_o;
            mip_pkg::REG_OT_HYST: rd_data = overtemp_hysteresis_limit_o;
            mip_pkg::REG_FAN1_LIM: rd_data = fan1_count_limit_o;
            mip_pkg::REG_FAN2_LIM: rd_data = fan2_count_limit_o;
            mip_pkg::REG_MAKER_ID: rd_data = mip_pkg::MAKER_ID_VALUE;
            default: rd_data = 8'h00;
        endcase
    end

    // Protocol sequencing
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= MIP_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            read_q <= 1'b0;
            byte_cnt_q <= 2'h0;
        end else if (start_det) begin
            state_q <= MIP_ADDR;
            bit_q <= 4'h0;
            byte_cnt_q <= 2'h0;
        end else if (stop_det) begin
            state_q <= MIP_IDLE;
        end else begin
            unique case (state_q)
                MIP_IDLE: begin
                end
                MIP_ADDR, MIP_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == mip_pkg::BIT_ACK) begin
                        bit_q <= 4'h0;
                        if (state_q == MIP_ADDR) begin
                            if (addr_match) begin
                                read_q <= shift_q[0];
                                state_q <= MIP_ACK;
                            end else begin
                                state_q <= MIP_IDLE;
                            end
                        end else if (byte_cnt_q != 2'h2) begin
                            byte_cnt_q <= byte_cnt_q + 2'h1;
                            state_q <= MIP_ACK;
                        end else begin
                            // Third byte refused: no acknowledge
                            state_q <= MIP_IDLE;
                        end
                    end
                end
                MIP_ACK: begin
                    if (scl_fall) begin
                        if (read_q) begin
                            shift_q <= rd_data;
                            state_q <= MIP_TX;
                        end else begin
                            state_q <= MIP_RX;
                        end
                    end
                end
                MIP_TX: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        if (bit_q == mip_pkg::BIT_LAST) begin
                            state_q <= MIP_TX_ACK;
                        end
                    end
                end
                MIP_TX_ACK: begin
                    // One byte per read; a further ack is not served
                    if (scl_fall) begin
                        state_q <= MIP_IDLE;
                    end
                end
                default: state_q <= MIP_IDLE;
            endcase
        end
    end

    // Byte bit counter reaches ACK position after eighth rise
    logic rx_byte_end;
    assign rx_byte_end = (state_q == MIP_RX) && scl_fall && (bit_q == mip_pkg::BIT_ACK)
        && (byte_cnt_q != 2'h2);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            addr_pointer_o <= mip_pkg::PTR_RESET;
        end else if (rx_byte_end && byte_cnt_q == 2'h0) begin
            addr_pointer_o <= shift_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            overtemp_high_limit_o <= mip_pkg::RST_OT_HIGH;
            overtemp_hysteresis_limit_o <= mip_pkg::RST_OT_HYST;
            fan1_count_limit_o <= mip_pkg::RST_FAN_LIM;
            fan2_count_limit_o <= mip_pkg::RST_FAN_LIM;
        end else if (rx_byte_end && byte_cnt_q == 2'h1) begin
            unique case (addr_pointer_o)
                mip_pkg::REG_OT_HIGH: overtemp_high_limit_o <= shift_q;
                mip_pkg::REG_OT_HYST: overtemp_hysteresis_limit_o <= shift_q;
                mip_pkg::REG_FAN1_LIM: fan1_count_limit_o <= shift_q;
                mip_pkg::REG_FAN2_LIM: fan2_count_limit_o <= shift_q;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pin: ack low, or transmit bit; updated at SCL falls, cleared at start or stop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sda_low_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_low_q <= 1'b0;
        end else if (scl_fall) begin
            if (state_q == MIP_ADDR || state_q == MIP_RX) begin
                sda_low_q <= (bit_q == mip_pkg::BIT_ACK) &&
                    (state_q == MIP_ADDR ? addr_match : byte_cnt_q != 2'h2);
            end else if (state_q == MIP_ACK) begin
                sda_low_q <= read_q && !rd_data[7];
            end else if (state_q == MIP_TX) begin
                sda_low_q <= (bit_q != mip_pkg::BIT_LAST) && !shift_q[6];
            end else begin
                sda_low_q <= 1'b0;
            end
        end
    end
    assign bus.sda_dev_o = 1'b0;
    assign bus.sda_dev_oe = sda_low_q;
    assign bus.scl_dev_o = 1'b1;
    assign bus.scl_dev_oe = 1'b0;
endmodule

/* File: design/mip_host.sv */
`timescale 1ns/1ns
module mip_host (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    mip_i2c_if.host bus
);
    // Control word: [1:0] operation, [2] go, [5:3] select pins of target
    typedef enum logic [2:0] {H_IDLE, H_START, H_BITS, H_STOP, H_DONE} mip_host_state_type;
    mip_host_state_type state_q;
    logic [9:0] div_q;
    logic [1:0] phase_q;
    logic tick;
    logic [2:0] sel_q;
    mip_pkg::mip_op_type op_q;
    logic [7:0] data_q;
    logic [7:0] regidx_q;
    logic [7:0] rx_q;
    logic nack_q;
    logic busy;
    logic [26:0] frame_q;
    logic [5:0] nbits_q;
    logic [5:0] idx_q;
    logic scl_low_q;
    logic sda_low_q;

    assign busy = (state_q != H_IDLE);
    assign tick = (div_q == mip_pkg::QUARTER_CNT);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !busy || tick) begin
            div_q <= 10'h000;
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel_q <= 3'h0;
            data_q <= 8'h00;
            regidx_q <= 8'h00;
            op_q <= mip_pkg::MIP_OP_PTR;
        end else if (wr_i && !busy) begin
            if (addr_i == mip_pkg::HREG_CTRL) begin
                op_q <= mip_pkg::mip_op_type'(wdata_i[1:0]);
                sel_q <= wdata_i[5:3];
            end else if (addr_i == mip_pkg::HREG_DATA) begin
                data_q <= wdata_i;
            end else if (addr_i == mip_pkg::HREG_REGIDX) begin
                regidx_q <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                mip_pkg::HREG_CTRL: rdata_o <= {2'h0, sel_q, 1'b0, op_q};
                mip_pkg::HREG_STATUS: rdata_o <= {6'h00, nack_q, busy};
                mip_pkg::HREG_DATA: rdata_o <= rx_q;
                mip_pkg::HREG_REGIDX: rdata_o <= regidx_q;
            endcase
        end
    end

    // Frame: address+dir+ack, then bytes each followed by an ack slot
    logic [7:0] addr_byte;
    logic go;
    logic cur_bit;
    logic ack_slot;
    logic read_slot;
    assign go = wr_i && !busy && addr_i == mip_pkg::HREG_CTRL && wdata_i[2];
    assign addr_byte = {mip_pkg::ADDR_FIXED, wdata_i[5:3],
        wdata_i[1:0] == mip_pkg::MIP_OP_READ};
    assign cur_bit = frame_q[26];
    assign ack_slot = (idx_q == 6'd8) || (idx_q == 6'd17) || (idx_q == 6'd26);
    assign read_slot = (op_q == mip_pkg::MIP_OP_READ) && idx_q > 6'd8 && idx_q < 6'd17;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= H_IDLE;
            phase_q <= 2'h0;
            frame_q <= 27'h0;
            nbits_q <= 6'h0;
            idx_q <= 6'h0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            rx_q <= 8'h00;
            nack_q <= 1'b0;
        end else if (go) begin
            state_q <= H_START;
            phase_q <= 2'h0;
            idx_q <= 6'h0;
            nack_q <= 1'b0;
            // Read NACKs its byte: ack slot bit kept high
            frame_q <= {addr_byte, 1'b1, (wdata_i[1:0] == mip_pkg::MIP_OP_PTR ? regidx_q :
                (wdata_i[1:0] == mip_pkg::MIP_OP_READ ? 8'hff : regidx_q)), 1'b1,
                data_q, 1'b1};
            nbits_q <= (wdata_i[1:0] == mip_pkg::MIP_OP_WRITE) ? 6'd27 : 6'd18;
        end else if (tick) begin
            phase_q <= phase_q + 2'h1;
            unique case (state_q)
                H_START: begin
                    if (phase_q == 2'h1) begin
                        sda_low_q <= 1'b1;
                    end else if (phase_q == 2'h3) begin
                        scl_low_q <= 1'b1;
                        state_q <= H_BITS;
                    end
                end
                H_BITS: begin
                    if (phase_q == 2'h0) begin
                        sda_low_q <= !cur_bit;
                    end else if (phase_q == 2'h1) begin
                        scl_low_q <= 1'b0;
                    end else if (phase_q == 2'h2) begin
                        // Own NACK slot of a read is not a refusal
                        if (ack_slot && bus.sda &&
                            !(op_q == mip_pkg::MIP_OP_READ && idx_q == 6'd17)) begin
                            nack_q <= 1'b1;
                        end
                        if (read_slot) begin
                            rx_q <= {rx_q[6:0], bus.sda};
                        end
                    end else begin
                        scl_low_q <= 1'b1;
                        frame_q <= {frame_q[25:0], 1'b1};
                        idx_q <= idx_q + 6'h1;
                        if (idx_q + 6'h1 == nbits_q || (idx_q == 6'd8 && nack_q)) begin
                            state_q <= H_STOP;
                        end
                    end
                end
                H_STOP: begin
                    if (phase_q == 2'h0) begin
                        sda_low_q <= 1'b1;
                    end else if (phase_q == 2'h1) begin
                        scl_low_q <= 1'b0;
                    end else if (phase_q == 2'h3) begin
                        sda_low_q <= 1'b0;
                        state_q <= H_DONE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end
    assign bus.scl_host_o = 1'b0;
    assign bus.scl_host_oe = scl_low_q;
    assign bus.sda_host_o = 1'b0;
    assign bus.sda_host_oe = sda_low_q;
endmodule

/* File: test/mip_chk.sv */
`timescale 1ns/1ns
module mip_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_dev_o,
    input wire logic scl_dev_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl_host_o,
    input wire logic scl_host_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////
    a_dev_no_scl: assert property (!scl_dev_oe)
        else $error("device drives the clock line");
    a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_o)
        else $error("device drives data high");
    a_host_open_drain: assert property (!(scl_host_oe && scl_host_o) &&
        !(sda_host_oe && sda_host_o))
        else $error("host drives a line high");
    // Device may only move data while the clock is low
    a_dev_stable_high: assert property ((scl && $past(scl)) |-> $stable(sda_dev_oe))
        else $error("device data moved while clock high");
    a_ack_low_phase: assert property ($changed(sda_dev_oe) |-> !scl [*3])
        else $error("device data edge too near a clock rise");
    a_host_start: assert property ((scl && $fell(sda)) |-> sda_host_oe)
        else $error("start not made by the host");
    a_stop_quiet: assert property ((scl && $rose(sda)) |-> !sda_dev_oe [*8])
        else $error("device drives data after stop");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_reset_release: assert property ($fell(sys_rst_i) |->
        !sda_dev_oe && !sda_host_oe && !scl_host_oe)
        else $error("lines not released after reset");
endmodule

/* File: test/test_monitor_i2c_register_port.sv */
`timescale 1ns/1ns
module test_monitor_i2c_register_port;
    logic clk_i;
    logic sys_rst_i;
    logic [2:0] pin_sel;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [7:0] ot_high, ot_hyst, fan1, fan2, ptr;
    logic [2:0] sel;
    logic [7:0] d, st;
    logic [8:0] shreg;
    int nbit;
    int errors;
    int cmp_count;
    int cycles;
    int seed;
    int mreg [int];
    int mptr;
    mip_i2c_if bus_if ();
    mip_device u_mip_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr_select_bit2_i(pin_sel[2]), .addr_select_bit1_i(pin_sel[1]),
        .addr_select_bit0_i(pin_sel[0]), .overtemp_high_limit_o(ot_high),
        .overtemp_hysteresis_limit_o(ot_hyst), .fan1_count_limit_o(fan1),
        .fan2_count_limit_o(fan2), .addr_pointer_o(ptr), .bus(bus_if));
    mip_host u_mip_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus(bus_if));
    mip_chk u_mip_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl(bus_if.scl), .sda(bus_if.sda),
        .scl_dev_o(bus_if.scl_dev_o), .scl_dev_oe(bus_if.scl_dev_oe),
        .sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe(bus_if.sda_dev_oe),
        .scl_host_o(bus_if.scl_host_o), .scl_host_oe(bus_if.scl_host_oe),
        .sda_host_o(bus_if.sda_host_o), .sda_host_oe(bus_if.sda_host_oe));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Wire monitor: address byte and its ack bit after the latest start
    always @(posedge bus_if.scl) begin
        if (nbit < 9) shreg = {shreg[7:0], bus_if.sda};
        nbit = nbit + 1;
    end
    always @(negedge bus_if.sda) begin
        if (bus_if.scl) nbit = 0;
    end
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 120000) begin
            errors = errors + 1;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] mval(input int i);
        if (i == int'(mip_pkg::REG_MAKER_ID)) return mip_pkg::MAKER_ID_VALUE;
        if (mreg.exists(i)) return mreg[i][7:0];
        return 8'h00;
    endfunction
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        // Data stand in the cycle after the strobe; taken at its closing edge
        @(posedge clk_i);
        v = rdata;
    endtask
    task automatic check_regs();
        check(ot_high, mval(32'h3a));
        check(ot_hyst, mval(32'h3b));
        check(fan1, mval(32'h3c));
        check(fan2, mval(32'h3d));
        check(ptr, 8'(mptr));
    endtask
    task automatic run_op(input mip_pkg::mip_op_type op, input logic [2:0] s,
        input logic [7:0] idx, input logic [7:0] v);
        int n;
        logic hit;
        logic [7:0] exp_a;
        repeat (8) @(posedge clk_i);
        reg_wr(mip_pkg::HREG_REGIDX, idx);
        reg_wr(mip_pkg::HREG_DATA, v);
        reg_wr(mip_pkg::HREG_CTRL, {2'h0, s, 1'b1, op});
        repeat (4) @(posedge clk_i);
        n = 0;
        st = 8'h01;
        while (st[0] !== 1'b0 && n < 60000) begin
            reg_rd(mip_pkg::HREG_STATUS, st);
            n = n + 1;
        end
        hit = (s == pin_sel);
        if (hit && op != mip_pkg::MIP_OP_READ) mptr = int'(idx);
        if (hit && op == mip_pkg::MIP_OP_WRITE && idx inside {[8'h3a:8'h3d]}) mreg[int'(idx)] = v;
        exp_a = {mip_pkg::ADDR_FIXED, s, op == mip_pkg::MIP_OP_READ};
        check(shreg[8:1], exp_a);
        check({7'h0, shreg[0]}, {7'h0, !hit});
        check({7'h0, st[1]}, {7'h0, !hit});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h199f588c;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        nbit = 9;
        shreg = 9'h000;
        sys_rst_i = 1'b1;
        pin_sel = 3'h0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        mreg[32'h3a] = 32'h55;
        mreg[32'h3b] = 32'h4b;
        mreg[32'h3c] = 32'hff;
        mreg[32'h3d] = 32'hff;
        mptr = 0;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check_regs();
        sel = 3'($random(seed));
        pin_sel <= sel;
        d = 8'($random(seed));
        run_op(mip_pkg::MIP_OP_WRITE, sel, mip_pkg::REG_OT_HIGH, d);
        check_regs();
        // Select pins move between operations; address follows them
        sel = sel + 3'h3;
        pin_sel <= sel;
        run_op(mip_pkg::MIP_OP_READ, sel, mip_pkg::REG_OT_HIGH, 8'h00);
        reg_rd(mip_pkg::HREG_DATA, d);
        check(d, mval(mptr));
        run_op(mip_pkg::MIP_OP_PTR, sel, mip_pkg::REG_MAKER_ID, 8'($random(seed)));
        check_regs();
        run_op(mip_pkg::MIP_OP_READ, sel, mip_pkg::REG_MAKER_ID, 8'h00);
        reg_rd(mip_pkg::HREG_DATA, d);
        check(d, mval(mptr));
        run_op(mip_pkg::MIP_OP_WRITE, sel ^ 3'h1, mip_pkg::REG_OT_HYST, 8'h00);
        check_regs();
        end_of_test();
    end
endmodule
